// ### design/sbc_mode_fsm.sv
// Operating-mode state machine with power-on strap capture and watchdog window
module sbc_mode_fsm
  import sbc_mode_pkg::*;
#(
  parameter int LONG_WINDOW_COUNT = LONG_WINDOW_CYC
)(
  input logic clk_sys,
  input logic nrst,
  input logic spiSclk,
  input logic spiCsN,
  input logic spiMosi,
  output logic spiMiso,
  output logic spiMisoEn,
  input logic intStrap,
  output logic intPullDownEn,
  input logic thirdFailOutputStrap,
  input logic wakeCan,
  input logic [2:0] wakeInputs,
  input logic mainRegUndervoltage,
  input logic mainRegOvervoltage,
  input logic ovResetEnable,
  input logic overtempActive,
  output logic mainRegulatorEnable,
  output logic resetOutputPinN,
  output mode_t modeState,
  output logic [1:0] modeField,
  output logic devMode,
  output logic cfgPullUp,
  output logic wdFailFlag
);
  mode_t state_reg;
  mode_t state_next;
  logic regEn_reg;
  logic ro_reg;
  logic porDone_reg;
  logic devMode_reg;
  logic cfgPullUp_reg;
  logic wdFail_reg;
  logic fsByTemp_reg;
  logic [1:0] modeField_reg;
  logic [1:0] modeField_next;
  logic frameValid;
  logic [FRAME_W-1:0] frameData;
  logic rdExpired;
  logic wdExpired;
  mode_t critTarget;

  // Frame decode
  wire isWrite = frameData[FRAME_WR_BIT];
  wire [6:0] frameAddr = frameData[ADDR_HI:ADDR_LO];
  wire [1:0] reqCode = frameData[MODE_HI:MODE_LO];
  wire modeWrite = frameValid && isWrite && (frameAddr == ADDR_MODE_CTRL);
  wire wdTrigger = frameValid && isWrite && (frameAddr == ADDR_WD_CTRL);
  wire statusRead = frameValid && !isWrite && (frameAddr == ADDR_STATUS);

  // Mode and event decode
  wire inInit = (state_reg == MODE_INIT);
  wire inRestart = (state_reg == MODE_RESTART);
  wire active = (state_reg == MODE_NORMAL) || (state_reg == MODE_STOP);
  wire anyWake = wakeCan || (|wakeInputs);
  wire porPhase = inInit && !porDone_reg;
  wire roRise = rdExpired && !ro_reg;
  wire ovFail = mainRegOvervoltage && ovResetEnable;
  wire critFail = wdExpired || ovFail;
  // Full mode width: a one-bit net would fold restart and fail-safe into init and normal
  assign critTarget = cfgPullUp_reg ? MODE_RESTART : MODE_FAILSAFE;
  wire enterRestart = (state_next == MODE_RESTART) && !inRestart;
  wire enterInit = (state_next == MODE_INIT) && !inInit;
  wire lowPower = (state_next == MODE_SLEEP) || (state_next == MODE_FAILSAFE);

  // Watchdog only runs with the microcontroller out of reset and never in development mode
  wire wdRun = !devMode_reg && ro_reg && (inInit || active);
  wire wdReload = wdTrigger || roRise || enterInit || !wdRun;
  // Delay restarts while undervoltage persists, so it counts from the clearing
  wire rdHold = (inRestart || porPhase) && mainRegUndervoltage;
  wire rdRun = (inRestart || porPhase) && !mainRegUndervoltage;

  spi_frame_rx u_rx (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .spiSclk(spiSclk),
    .spiCsN(spiCsN),
    .spiMosi(spiMosi),
    .txWord({STATUS_PAD, state_reg, devMode_reg, cfgPullUp_reg, wdFail_reg, modeField_reg}),
    .spiMiso(spiMiso),
    .spiMisoEn(spiMisoEn),
    .frameValid(frameValid),
    .frameData(frameData)
  );

  delay_timer #(.LIMIT(RESET_DELAY_CYC)) u_rd (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(enterRestart || rdHold),
    .enable(rdRun),
    .expired(rdExpired)
  );

  delay_timer #(.LIMIT(LONG_WINDOW_COUNT)) u_lw (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(wdReload),
    .enable(wdRun),
    .expired(wdExpired)
  );

  // Next mode; failures outrank host requests
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      MODE_INIT:
      begin
        // Wakes have no path out of init and are dropped
        if (wdExpired)
          state_next = MODE_RESTART;
        else if (ro_reg && frameValid)
          state_next = MODE_NORMAL;
      end
      MODE_NORMAL, MODE_STOP:
      begin
        if (overtempActive)
          state_next = MODE_FAILSAFE;
        else if (critFail)
          state_next = mode_t'(critTarget);
        else if (mainRegUndervoltage)
          state_next = MODE_RESTART;
        else if (modeWrite)
        begin
          unique case (reqCode)
            REQ_NORMAL: state_next = MODE_NORMAL;
            REQ_STOP: state_next = MODE_STOP;
            REQ_SLEEP: state_next = MODE_SLEEP;
            REQ_SOFT_RESET: state_next = MODE_INIT;
          endcase
        end
      end
      MODE_SLEEP:
      begin
        if (anyWake)
          state_next = MODE_RESTART;
      end
      MODE_RESTART:
      begin
        if (rdExpired)
          state_next = MODE_NORMAL;
      end
      MODE_FAILSAFE:
      begin
        if (anyWake || (fsByTemp_reg && !overtempActive))
          state_next = MODE_RESTART;
      end
      default:
        state_next = MODE_INIT;
    endcase
  end

  always_comb
  begin
    modeField_next = modeField_reg;
    if (state_next == MODE_RESTART || state_next == MODE_INIT)
      modeField_next = MODE_FIELD_RST;
    else if (modeWrite && active && reqCode != REQ_SOFT_RESET)
      modeField_next = reqCode;
  end

  // Async reset puts every flop at a constant; straps are caught later on the clock
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= MODE_INIT;
      modeField_reg <= MODE_FIELD_RST;
      regEn_reg <= 1'b1;
      ro_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      modeField_reg <= modeField_next;
      regEn_reg <= !lowPower;
      if (state_next == MODE_RESTART)
        ro_reg <= 1'b0;
      else if (rdExpired)
        ro_reg <= 1'b1;
    end
  end

  // Straps sampled only at the first release of the reset output after power-on
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      porDone_reg <= 1'b0;
      cfgPullUp_reg <= 1'b0;
      devMode_reg <= 1'b0;
    end
    else if (roRise && porPhase)
    begin
      porDone_reg <= 1'b1;
      cfgPullUp_reg <= intStrap;
      devMode_reg <= !thirdFailOutputStrap;
    end
  end

  // Watchdog failure flag: a new failure wins over a status read
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wdFail_reg <= 1'b0;
      fsByTemp_reg <= 1'b0;
    end
    else
    begin
      if (wdExpired)
        wdFail_reg <= 1'b1;
      else if (statusRead)
        wdFail_reg <= 1'b0;
      if (state_next == MODE_FAILSAFE && state_reg != MODE_FAILSAFE)
        fsByTemp_reg <= overtempActive;
    end
  end

  assign intPullDownEn = porPhase && !ro_reg;
  assign mainRegulatorEnable = regEn_reg;
  assign resetOutputPinN = ro_reg;
  assign modeState = state_reg;
  assign modeField = modeField_reg;
  assign devMode = devMode_reg;
  assign cfgPullUp = cfgPullUp_reg;
  assign wdFailFlag = wdFail_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  property p_stop_reg_on;
    state_reg == MODE_STOP |-> mainRegulatorEnable;
  endproperty
  a_stop_reg_on: assert property (p_stop_reg_on) else $error("regulator off in stop");

  property p_sleep_reg_off;
    (state_reg == MODE_SLEEP) || (state_reg == MODE_FAILSAFE) |-> !mainRegulatorEnable;
  endproperty
  a_sleep_reg_off: assert property (p_sleep_reg_off) else $error("regulator on in low power");

  property p_restart_reset;
    inRestart |-> !resetOutputPinN && modeField == MODE_FIELD_RST;
  endproperty
  a_restart_reset: assert property (p_restart_reset) else $error("restart without reset");

  property p_restart_exit;
    inRestart && rdExpired |=> state_reg == MODE_NORMAL && resetOutputPinN;
  endproperty
  a_restart_exit: assert property (p_restart_exit) else $error("restart not left");

  property p_init_frame;
    inInit && ro_reg && frameValid && !wdExpired |=> state_reg == MODE_NORMAL;
  endproperty
  a_init_frame: assert property (p_init_frame) else $error("init ignored frame");

  property p_init_wake;
    inInit && anyWake && !frameValid && !wdExpired |=> state_reg == MODE_INIT;
  endproperty
  a_init_wake: assert property (p_init_wake) else $error("wake left init");

  property p_dev_no_wd;
    devMode_reg |-> !wdExpired;
  endproperty
  a_dev_no_wd: assert property (p_dev_no_wd) else $error("watchdog ran in dev mode");

  property p_stop_req;
    state_reg == MODE_NORMAL && modeWrite && reqCode == REQ_STOP && !critFail
      && !overtempActive && !mainRegUndervoltage |=> state_reg == MODE_STOP ##1 modeField == REQ_STOP;
  endproperty
  a_stop_req: assert property (p_stop_req) else $error("stop request lost");

  property p_fs_hold;
    state_reg == MODE_FAILSAFE && !anyWake && !fsByTemp_reg |=> state_reg == MODE_FAILSAFE;
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("fail-safe left early");

  property p_strap;
    roRise && porPhase |=> cfgPullUp == $past(intStrap) && devMode == !$past(thirdFailOutputStrap);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not latched");
endmodule

// ### pkg/sbc_mode_pkg.sv
// Constants, frame layout and mode encoding for the operating-mode sequencer
package sbc_mode_pkg;
  localparam int CLK_FREQ_MHZ = 10;
  localparam int RESET_DELAY_US = 10;
  localparam int LONG_WINDOW_MS = 200;
  localparam int RESET_DELAY_CYC = RESET_DELAY_US * CLK_FREQ_MHZ;
  localparam int LONG_WINDOW_CYC = LONG_WINDOW_MS * 1000 * CLK_FREQ_MHZ;
  localparam int TIMER_W = 24;

  localparam int FRAME_W = 16;
  localparam int FRAME_CNT_W = 5;
  localparam logic [FRAME_CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam int FRAME_WR_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 8;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
  localparam logic [6:0] ADDR_WD_CTRL = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [7:0] STATUS_PAD = 8'h00;

  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_STOP = 2'h2;
  localparam logic [1:0] REQ_SOFT_RESET = 2'h3;
  localparam logic [1:0] MODE_FIELD_RST = 2'h0;

  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } mode_t;
endpackage

// ### design/delay_timer.sv
// Down-counting delay timer with reload and a one-cycle expiry pulse
module delay_timer
  import sbc_mode_pkg::*;
#(
  parameter int LIMIT = RESET_DELAY_CYC
)(
  input logic clk_sys,
  input logic nrst,
  input logic start,
  input logic enable,
  output logic expired
);
  localparam logic [TIMER_W-1:0] LOAD = TIMER_W'(LIMIT);
  localparam logic [TIMER_W-1:0] ONE = 24'h000001;
  localparam logic [TIMER_W-1:0] ZERO = 24'h000000;

  logic [TIMER_W-1:0] cnt_reg;
  logic [TIMER_W-1:0] cnt_next;
  wire running = enable && (cnt_reg != ZERO);

  // Expires once, then parks at zero until reloaded
  assign expired = !start && enable && (cnt_reg == ONE);
  assign cnt_next = start ? LOAD : (running ? cnt_reg - ONE : cnt_reg);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= LOAD;
    else
      cnt_reg <= cnt_next;
  end
endmodule

// ### design/spi_frame_rx.sv
// SPI slave, mode 0, that takes only whole 16-bit frames
module spi_frame_rx
  import sbc_mode_pkg::*;
(
  input logic clk_sys,
  input logic nrst,
  input logic spiSclk,
  input logic spiCsN,
  input logic spiMosi,
  input logic [FRAME_W-1:0] txWord,
  output logic spiMiso,
  output logic spiMisoEn,
  output logic frameValid,
  output logic [FRAME_W-1:0] frameData
);
  logic sclk_reg;
  logic cs_reg;
  logic [FRAME_CNT_W-1:0] bitCnt_reg;
  logic [FRAME_W-1:0] rx_reg;
  logic [FRAME_W-1:0] tx_reg;
  logic valid_reg;

  wire sclkRise = spiSclk && !sclk_reg;
  wire sclkFall = !spiSclk && sclk_reg;
  wire csFall = !spiCsN && cs_reg;
  wire csRise = spiCsN && !cs_reg;
  // Short or long frames are dropped whole
  wire frameOk = csRise && (bitCnt_reg == FRAME_BITS);
  wire [FRAME_CNT_W-1:0] cntInc = bitCnt_reg + FRAME_CNT_W'(1);

  assign spiMiso = tx_reg[FRAME_W-1];
  assign spiMisoEn = !spiCsN;
  assign frameValid = valid_reg;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_reg <= 1'b0;
      cs_reg <= 1'b1;
      bitCnt_reg <= '0;
      rx_reg <= '0;
      tx_reg <= '0;
      valid_reg <= 1'b0;
      frameData <= '0;
    end
    else
    begin
      sclk_reg <= spiSclk;
      cs_reg <= spiCsN;
      valid_reg <= frameOk;
      if (frameOk)
        frameData <= rx_reg;
      if (csFall)
      begin
        bitCnt_reg <= '0;
        tx_reg <= txWord;
      end
      else if (!spiCsN && sclkRise)
      begin
        rx_reg <= {rx_reg[FRAME_W-2:0], spiMosi};
        if (bitCnt_reg != FRAME_BITS + FRAME_CNT_W'(1))
          bitCnt_reg <= cntInc;
      end
      else if (!spiCsN && sclkFall)
        tx_reg <= {tx_reg[FRAME_W-2:0], 1'b0};
    end
  end
endmodule

// ### test/spi_host_model.sv
// Host microcontroller model: SPI mode 0 master that sends whole or cut-short frames
module spi_host_model
  import sbc_mode_pkg::*;
(
  input logic clk_sys,
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi,
  input logic spiMiso,
  input logic spiMisoEn
);
  timeunit 1ns;
  timeprecision 1ns;
  int halfCyc = 2;
  logic busy = 1'b0;

  initial
  begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end

  // Data line toggles between frames so a stale bit is never mistaken for a held one
  always @(posedge clk_sys)
    if (!busy)
      spiMosi <= ~spiMosi;

  // Clock stands low outside frames; a count other than 16 gives a frame to be dropped
  task automatic xfer(input logic [FRAME_W-1:0] word, input int nbits, output logic [FRAME_W-1:0] rx);
    busy = 1'b1;
    rx = '0;
    @(posedge clk_sys);
    #10;
    spiCsN = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      spiMosi = word[FRAME_W-1-i];
      repeat (halfCyc) @(posedge clk_sys);
      #10;
      rx = {rx[FRAME_W-2:0], spiMisoEn ? spiMiso : 1'bx};
      spiSclk = 1'b1;
      repeat (halfCyc) @(posedge clk_sys);
      #10;
      spiSclk = 1'b0;
    end
    repeat (halfCyc) @(posedge clk_sys);
    #10;
    spiCsN = 1'b1;
    busy = 1'b0;
    repeat (2) @(posedge clk_sys);
    // Hand back off the edge so callers never sample or drive in the launch step
    #10;
  endtask
endmodule

// ### test/sbc_mode_fsm_tb.sv
// Self-checking bench for the operating-mode state machine
module sbc_mode_fsm_tb
  import sbc_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WIN = 2000;
  logic clk_sys, nrst, spiSclk, spiCsN, spiMosi, spiMiso, spiMisoEn, intStrap, intPullDownEn;
  logic thirdFailOutputStrap, wakeCan, mainRegUndervoltage, overtempActive, mainRegulatorEnable;
  logic resetOutputPinN, devMode, cfgPullUp, wdFailFlag;
  logic mainRegOvervoltage = 1'b0;
  logic ovResetEnable = 1'b0;
  logic [2:0] wakeInputs;
  logic [1:0] modeField;
  logic [15:0] rxWord;
  mode_t modeState;
  mode_t prevMode = MODE_INIT;
  mode_t expQ[$];
  mode_t modeSeq[3] = '{MODE_STOP, MODE_NORMAL, MODE_SLEEP};
  logic [1:0] codes[3] = '{REQ_STOP, REQ_NORMAL, REQ_SLEEP};
  logic regOn[3] = '{1'b1, 1'b1, 1'b0};
  int num_errors = 0;
  int check_count = 0;
  int seed;
  int idx;

  sbc_mode_fsm #(.LONG_WINDOW_COUNT(WIN)) dut (.clk_sys(clk_sys), .nrst(nrst), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoEn(spiMisoEn), .intStrap(intStrap),
    .intPullDownEn(intPullDownEn), .thirdFailOutputStrap(thirdFailOutputStrap), .wakeCan(wakeCan),
    .wakeInputs(wakeInputs), .mainRegUndervoltage(mainRegUndervoltage), .mainRegOvervoltage(mainRegOvervoltage),
    .ovResetEnable(ovResetEnable), .overtempActive(overtempActive), .mainRegulatorEnable(mainRegulatorEnable),
    .resetOutputPinN(resetOutputPinN), .modeState(modeState), .modeField(modeField), .devMode(devMode),
    .cfgPullUp(cfgPullUp), .wdFailFlag(wdFailFlag));

  spi_host_model host (.clk_sys(clk_sys), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoEn(spiMisoEn));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Errors %0d, comparisons %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Every mode change must match the oldest note left by the driver
  always @(posedge clk_sys)
  begin
    #1;
    if (modeState !== prevMode)
    begin
      prevMode = modeState;
      if (expQ.size() == 0)
        check(modeState, 16'hFFFF);
      else
        check(modeState, expQ.pop_front());
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask

  task automatic send(input logic [15:0] w);
    host.xfer(w, FRAME_W, rxWord);
  endtask

  task automatic wait_mode(input mode_t m, input int lim);
    int n;
    n = 0;
    while (modeState !== m && n < lim)
    begin
      tick(1);
      n++;
    end
    check(modeState, m);
  endtask

  // Restart must still hold after 90 cycles of the reset delay, then hand over to normal within 20 more
  task automatic restart_exit();
    tick(90);
    check({modeState, resetOutputPinN}, {MODE_RESTART, 1'b0});
    wait_mode(MODE_NORMAL, 20);
    check(resetOutputPinN, 1'b1);
  endtask

  task automatic power_up(input logic cfg, input logic test);
    int n;
    nrst = 1'b0;
    intStrap = cfg;
    thirdFailOutputStrap = test;
    tick(6);
    check({modeState, mainRegulatorEnable, resetOutputPinN}, {MODE_INIT, 2'b10});
    check(intPullDownEn, 1'b1);
    nrst = 1'b1;
    tick(95);
    check(resetOutputPinN, 1'b0);
    n = 0;
    while (resetOutputPinN !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    intStrap = ~cfg;
    thirdFailOutputStrap = ~test;
    tick(2);
    check({devMode, cfgPullUp, intPullDownEn}, {~test, cfg, 1'b0});
  endtask

  initial
  begin
    seed = 32'hBCFA;
    wakeCan = 1'b0;
    wakeInputs = 3'h0;
    mainRegUndervoltage = 1'b0;
    overtempActive = 1'b0;
    power_up(1'b1, 1'b1);
    wakeCan = 1'b1;
    host.xfer(16'h8180, 15, rxWord);
    wakeCan = 1'b0;
    tick(4);
    check(modeState, MODE_INIT);
    expQ.push_back(MODE_NORMAL);
    send(16'h0300);
    check(rxWord, 16'h0008);
    wait_mode(MODE_NORMAL, 4);
    for (int i = 0; i < 3; i++)
    begin
      host.halfCyc = 2 + 2 * (i % 2);
      send(16'h8200);
      expQ.push_back(modeSeq[i]);
      send({8'h81, codes[i], 6'h00});
      wait_mode(modeSeq[i], 4);
      check({mainRegulatorEnable, modeField}, {regOn[i], codes[i]});
    end
    idx = $unsigned($random(seed)) % 4;
    expQ.push_back(MODE_RESTART);
    expQ.push_back(MODE_NORMAL);
    if (idx == 0)
      wakeCan = 1'b1;
    else
      wakeInputs[idx-1] = 1'b1;
    wait_mode(MODE_RESTART, 3);
    check({resetOutputPinN, mainRegulatorEnable, modeField}, 16'h4);
    wakeCan = 1'b0;
    wakeInputs = 3'h0;
    restart_exit();
    send(16'h8200);
    expQ.push_back(MODE_RESTART);
    expQ.push_back(MODE_NORMAL);
    mainRegUndervoltage = 1'b1;
    wait_mode(MODE_RESTART, 3);
    tick(120 + $unsigned($random(seed)) % 40);
    mainRegUndervoltage = 1'b0;
    restart_exit();
    expQ.push_back(MODE_INIT);
    send(16'h81C0);
    wait_mode(MODE_INIT, 4);
    check(modeField, REQ_NORMAL);
    expQ.push_back(MODE_NORMAL);
    send(16'h8200);
    wait_mode(MODE_NORMAL, 4);
    expQ.push_back(MODE_RESTART);
    expQ.push_back(MODE_NORMAL);
    wait_mode(MODE_RESTART, WIN + 300);
    check(wdFailFlag, 1'b1);
    restart_exit();
    send(16'h0300);
    check({rxWord, wdFailFlag}, {16'h002C, 1'b0});
    expQ.push_back(MODE_FAILSAFE);
    overtempActive = 1'b1;
    wait_mode(MODE_FAILSAFE, 3);
    tick(30);
    check({modeState, mainRegulatorEnable}, {MODE_FAILSAFE, 1'b0});
    expQ.push_back(MODE_RESTART);
    expQ.push_back(MODE_NORMAL);
    overtempActive = 1'b0;
    wait_mode(MODE_RESTART, 3);
    restart_exit();
    expQ.push_back(MODE_INIT);
    power_up(1'b0, 1'b0);
    expQ.push_back(MODE_NORMAL);
    send(16'h0300);
    tick(WIN + 200);
    check({modeState, wdFailFlag}, {MODE_NORMAL, 1'b0});
    expQ.push_back(MODE_STOP);
    send(16'h8180);
    wait_mode(MODE_STOP, 4);
    expQ.push_back(MODE_FAILSAFE);
    ovResetEnable = 1'b1;
    mainRegOvervoltage = 1'b1;
    wait_mode(MODE_FAILSAFE, 3);
    mainRegOvervoltage = 1'b0;
    tick(20);
    check({modeState, mainRegulatorEnable}, {MODE_FAILSAFE, 1'b0});
    expQ.push_back(MODE_RESTART);
    expQ.push_back(MODE_NORMAL);
    wakeCan = 1'b1;
    wait_mode(MODE_RESTART, 3);
    wakeCan = 1'b0;
    restart_exit();
    check(expQ.size(), 16'h0);
    test_done();
  end

  // Hang guard, well beyond the expected run of roughly six thousand cycles
  initial
  begin
    #(30000 * 100);
    num_errors++;
    $display("unexpected at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
    test_done();
  end
endmodule
